// *** logic/scd_pkg.sv ***
`default_nettype none
package scd_pkg;
  // Bank select lives at this I/O port, only one bit is implemented
  localparam logic [3:0]  BANK_PORT    = 4'hd;
  localparam int          BANK_BIT     = 2;
  localparam logic [3:0]  BANK_MASK    = 4'h4;
  localparam int          COMMON_BIT   = 11;
  localparam logic [11:0] RESET_VEC    = 12'h008;
  localparam logic [7:0]  RSTK_STEP    = 8'h04;
  localparam logic [7:0]  ONE8         = 8'h01;
  localparam logic [7:0]  TWO8         = 8'h02;
  localparam logic [7:0]  THREE8       = 8'h03;
  localparam logic [11:0] ONE12        = 12'h001;
  // Per-level service vectors, level 7 is the highest priority
  localparam logic [7:0][11:0] IRQ_VEC = {12'h1e0, 12'h1c0, 12'h180, 12'h140,
                                          12'h100, 12'h0c0, 12'h080, 12'h040};
  // Condition flag positions, bit 2 reads zero
  localparam int          FLG_C        = 0;
  localparam int          FLG_B        = 1;
  localparam int          FLG_I        = 3;
  localparam logic [3:0]  FLG_WR_MASK  = 4'h3;
  // Opcode groups in the high nibble
  localparam logic [3:0]  GRP_ALU      = 4'h0;
  localparam logic [3:0]  GRP_LIT      = 4'h1;
  localparam logic [3:0]  GRP_MISC     = 4'h2;
  localparam logic [3:0]  GRP_PLOAD    = 4'h3;
  localparam logic [3:0]  GRP_BR       = 4'h4;
  localparam logic [3:0]  GRP_JMP      = 4'h5;
  localparam logic [3:0]  GRP_CALL     = 4'h6;
  localparam logic [3:0]  GRP_MEM      = 4'h7;
  localparam logic [7:0]  OP_NOP       = 8'h00;
  localparam logic [3:0]  ALU_ADD      = 4'h1;
  localparam logic [3:0]  ALU_SUB      = 4'h2;
  localparam logic [3:0]  ALU_AND      = 4'h3;
  localparam logic [3:0]  ALU_OR       = 4'h4;
  localparam logic [3:0]  ALU_XOR      = 4'h5;
  localparam logic [3:0]  ALU_SHL      = 4'h6;
  localparam logic [3:0]  ALU_ROR      = 4'h7;
  localparam logic [3:0]  ALU_NOT      = 4'h8;
  localparam logic [7:0]  OP_DROP      = 8'h20;
  localparam logic [7:0]  OP_DUP       = 8'h21;
  localparam logic [7:0]  OP_IN        = 8'h22;
  localparam logic [7:0]  OP_OUT       = 8'h23;
  localparam logic [7:0]  OP_MASK_ALL  = 8'h24;
  localparam logic [7:0]  OP_UNMASK    = 8'h25;
  localparam logic [7:0]  OP_SLEEP     = 8'h26;
  localparam logic [7:0]  OP_SET_FLAGS = 8'h27;
  localparam logic [7:0]  OP_FLIP_JUMP = 8'h28;
  localparam logic [7:0]  OP_WR_FLAGS  = 8'h29;
  localparam logic [7:0]  OP_RD_FLAGS  = 8'h2a;
  localparam logic [7:0]  OP_TABLE     = 8'h2b;
  localparam logic [7:0]  OP_RET       = 8'h2c;
  localparam logic [7:0]  OP_RET_IRQ   = 8'h2d;
  // Memory op fields: bit0 store, bit1 second pointer, bits 3:2 mode
  localparam int          MEM_STORE    = 0;
  localparam int          MEM_PTR2     = 1;
  localparam logic [1:0]  MODE_PLAIN   = 2'h0;
  localparam logic [1:0]  MODE_PREINC  = 2'h1;
  localparam logic [1:0]  MODE_POSTDEC = 2'h2;
  // Machine cycles per instruction class
  localparam logic [1:0]  CYC_ONE      = 2'h0;
  localparam logic [1:0]  CYC_TWO      = 2'h1;
  localparam logic [1:0]  CYC_THREE    = 2'h2;

  typedef enum logic [0:0] {
    ST_RUN  = 1'b0,
    ST_IACK = 1'b1
  } scd_state_t;

  typedef struct packed {
    scd_state_t      st;
    logic            system_tick;
    logic [1:0]      mcyc;
    logic [7:0]      ir;
    logic [7:0]      opnd;
    logic [11:0]     fetch_ptr;
    logic [3:0]      rom_bank_select;
    logic [7:0]      estk_ptr;
    logic [7:0]      rstk_ptr;
    logic [7:0]      ram_ptr_one;
    logic [7:0]      ram_ptr_two;
    logic [3:0]      top_item;
    logic [3:0]      condition_flags;
    logic [7:0]      pend;
    logic [7:0]      act;
    logic [12:0]     rom_addr;
    logic [3:0]      io_addr;
    logic [3:0]      io_wdata;
    logic            io_rd;
    logic            io_wr;
    logic [255:0][3:0] ram;
  } scd_core_t;
endpackage
`default_nettype wire

// *** logic/scd_core.sv ***
`timescale 1ns/100ps
`default_nettype none
module scd_core
  import scd_pkg::*;
#(
  parameter int NUM_LEVELS = 8
) (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic [7:0]  rom_data,
  input  wire logic [3:0]  io_rdata,
  input  wire logic [7:0]  irq_req,
  output var  logic [12:0] rom_addr,
  output var  logic [3:0]  io_addr,
  output var  logic [3:0]  io_wdata,
  output var  logic        io_rd,
  output var  logic        io_wr,
  output var  logic [7:0]  irq_active,
  output var  logic        int_enable,
  output var  logic        system_tick
);

  // Vector table and priority encoder are sized for exactly eight levels
  if (NUM_LEVELS != 8) begin : g_bad_levels
    $error("NUM_LEVELS must be 8");
  end

  scd_core_t   st_q;
  scd_core_t   st_d;
  logic [3:0]  second_item;
  logic [4:0]  alu_wide;
  logic [3:0]  alu_res;
  logic        alu_cy;
  logic        alu_bin;
  logic        alu_bool;
  logic        last_cyc;
  logic [3:0]  pend_hi;
  logic [3:0]  act_hi;
  logic        take_irq;
  logic [7:0]  mem_ptr;
  logic [7:0]  mem_new;
  logic [7:0]  rs_up;
  logic [11:0] rs_top;
  logic        io_op;
  logic [7:0]  lvl_bit;

  ////////////////////////////////////////////////////////////////////////
  // Decoding helpers

  // Only the upper half of a bank sees the bank bit
  function automatic logic [12:0] rom_map(input logic [11:0] ptr, input logic [3:0] bank);
    rom_map = {ptr[COMMON_BIT] & bank[BANK_BIT], ptr};
  endfunction

  function automatic logic [1:0] ncyc(input logic [7:0] op);
    logic [3:0] grp;
    grp = op[7:4];
    if (op == OP_TABLE) begin
      ncyc = CYC_THREE;
    end else if (grp == GRP_BR || grp == GRP_JMP || grp == GRP_CALL || op[7]) begin
      ncyc = CYC_TWO;
    end else if (op == OP_RET || op == OP_RET_IRQ || op == OP_IN) begin
      ncyc = CYC_TWO;
    end else begin
      ncyc = CYC_ONE;
    end
  endfunction

  // Highest set level with a valid bit on top
  function automatic logic [3:0] hi_level(input logic [7:0] v);
    hi_level = 4'h0;
    for (int i = 0; i < 8; i++) begin
      if (v[i]) begin
        hi_level = {1'b1, 3'(i)};
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic, all work happens on the machine-cycle tick

  always_comb begin
    st_d        = st_q;
    second_item = st_q.ram[st_q.estk_ptr];
    alu_wide    = 5'h00;
    alu_res     = 4'h0;
    alu_cy      = st_q.condition_flags[FLG_C];
    alu_bin     = 1'b0;
    alu_bool    = 1'b0;
    last_cyc    = (st_q.mcyc == ncyc(st_q.ir));
    pend_hi     = hi_level(st_q.pend);
    act_hi      = hi_level(st_q.act);
    take_irq    = st_q.condition_flags[FLG_I] && pend_hi[3] &&
                  (!act_hi[3] || pend_hi[2:0] > act_hi[2:0]);
    mem_ptr     = st_q.ir[MEM_PTR2] ? st_q.ram_ptr_two : st_q.ram_ptr_one;
    mem_new     = mem_ptr;
    rs_up       = st_q.rstk_ptr + RSTK_STEP;
    rs_top      = {st_q.ram[8'(st_q.rstk_ptr - TWO8)], st_q.ram[8'(st_q.rstk_ptr - ONE8)],
                   st_q.ram[st_q.rstk_ptr]};
    io_op       = (st_q.ir == OP_IN) || (st_q.ir == OP_OUT);
    lvl_bit     = 8'h01 << pend_hi[2:0];
    st_d.system_tick = ~st_q.system_tick;

    // ALU operand convention: second item and top item in, top item out
    unique case (st_q.ir[3:0])
      ALU_ADD: begin
        alu_wide = {1'b0, second_item} + {1'b0, st_q.top_item};
        alu_bin  = 1'b1;
      end
      ALU_SUB: begin
        alu_wide = {1'b0, second_item} - {1'b0, st_q.top_item};
        alu_bin  = 1'b1;
      end
      ALU_AND: begin
        alu_wide = {alu_cy, second_item & st_q.top_item};
        alu_bin  = 1'b1;
        alu_bool = 1'b1;
      end
      ALU_OR: begin
        alu_wide = {alu_cy, second_item | st_q.top_item};
        alu_bin  = 1'b1;
        alu_bool = 1'b1;
      end
      ALU_XOR: begin
        alu_wide = {alu_cy, second_item ^ st_q.top_item};
        alu_bin  = 1'b1;
        alu_bool = 1'b1;
      end
      ALU_SHL: alu_wide = {st_q.top_item, alu_cy};
      ALU_ROR: alu_wide = {st_q.top_item[0], alu_cy, st_q.top_item[3:1]};
      ALU_NOT: begin
        alu_wide = {alu_cy, ~st_q.top_item};
        alu_bool = 1'b1;
      end
      default: alu_wide = {alu_cy, st_q.top_item};
    endcase
    alu_res = alu_wide[3:0];
    alu_cy  = alu_wide[4];

    if (st_q.system_tick) begin
      // Strobes last one machine cycle
      st_d.io_rd = 1'b0;
      st_d.io_wr = 1'b0;
      st_d.mcyc  = st_q.mcyc + 2'h1;
      // Requests are logged every non-I/O cycle, even while disabled
      if (!io_op) begin
        st_d.pend = st_q.pend | irq_req;
      end

      unique case (st_q.st)
        ST_IACK: begin
          // Vector call: save the return address and enter the service routine
          st_d.rstk_ptr                = rs_up;
          st_d.ram[rs_up]              = st_q.fetch_ptr[3:0];
          st_d.ram[8'(rs_up - ONE8)]   = st_q.fetch_ptr[7:4];
          st_d.ram[8'(rs_up - TWO8)]   = st_q.fetch_ptr[11:8];
          st_d.fetch_ptr               = IRQ_VEC[pend_hi[2:0]];
          st_d.act                     = st_q.act | lvl_bit;
          st_d.ir                      = OP_NOP;
          st_d.mcyc                    = CYC_ONE;
          st_d.st                      = ST_RUN;
        end
        ST_RUN: begin
          unique case (st_q.ir[7:4])
            GRP_ALU: begin
              if (st_q.ir != OP_NOP) begin
                st_d.top_item = alu_res;
                st_d.condition_flags[FLG_B] = alu_bool ? (alu_res == 4'h0) : alu_cy;
                if (!alu_bool) begin
                  st_d.condition_flags[FLG_C] = alu_cy;
                end
                if (alu_bin) begin
                  st_d.estk_ptr = st_q.estk_ptr - ONE8;
                end
              end
            end
            GRP_LIT: begin
              st_d.estk_ptr               = st_q.estk_ptr + ONE8;
              st_d.ram[st_d.estk_ptr]     = st_q.top_item;
              st_d.top_item               = st_q.ir[3:0];
            end
            GRP_MISC: begin
              unique case (st_q.ir)
                OP_DROP: begin
                  st_d.top_item = second_item;
                  st_d.estk_ptr = st_q.estk_ptr - ONE8;
                end
                OP_DUP: begin
                  st_d.estk_ptr           = st_q.estk_ptr + ONE8;
                  st_d.ram[st_d.estk_ptr] = st_q.top_item;
                end
                OP_IN: begin
                  // Bank register is served inside the core, never on the bus
                  if (st_q.mcyc == CYC_ONE) begin
                    st_d.io_addr = st_q.top_item;
                    st_d.io_rd   = (st_q.top_item != BANK_PORT);
                  end else begin
                    st_d.top_item = (st_q.io_addr == BANK_PORT) ?
                                    (st_q.rom_bank_select & BANK_MASK) : io_rdata;
                  end
                end
                OP_OUT: begin
                  if (st_q.top_item == BANK_PORT) begin
                    st_d.rom_bank_select = second_item & BANK_MASK;
                  end else begin
                    st_d.io_addr  = st_q.top_item;
                    st_d.io_wdata = second_item;
                    st_d.io_wr    = 1'b1;
                  end
                  st_d.top_item = st_q.ram[8'(st_q.estk_ptr - ONE8)];
                  st_d.estk_ptr = st_q.estk_ptr - TWO8;
                end
                OP_MASK_ALL:  st_d.condition_flags[FLG_I] = 1'b0;
                OP_UNMASK:    st_d.condition_flags[FLG_I] = 1'b1;
                OP_SLEEP:     st_d.condition_flags[FLG_I] = 1'b1;
                OP_SET_FLAGS: begin
                  st_d.condition_flags[FLG_C] = 1'b1;
                  st_d.condition_flags[FLG_B] = 1'b1;
                end
                OP_FLIP_JUMP: st_d.condition_flags[FLG_B] = ~st_q.condition_flags[FLG_B];
                OP_WR_FLAGS: begin
                  // Enable bit is not writable here so only the enable ops can set it
                  st_d.condition_flags = (st_q.condition_flags & ~FLG_WR_MASK) |
                                         (st_q.top_item & FLG_WR_MASK);
                  st_d.top_item = second_item;
                  st_d.estk_ptr = st_q.estk_ptr - ONE8;
                end
                OP_RD_FLAGS: begin
                  st_d.estk_ptr           = st_q.estk_ptr + ONE8;
                  st_d.ram[st_d.estk_ptr] = st_q.top_item;
                  st_d.top_item           = st_q.condition_flags;
                end
                OP_TABLE: begin
                  // Constant sits in the current page, low byte from the two top nibbles
                  if (st_q.mcyc == CYC_TWO) begin
                    st_d.ram[st_q.estk_ptr] = rom_data[7:4];
                    st_d.top_item           = rom_data[3:0];
                  end
                end
                OP_RET, OP_RET_IRQ: begin
                  if (st_q.mcyc == CYC_ONE) begin
                    st_d.fetch_ptr = rs_top;
                    st_d.rstk_ptr  = st_q.rstk_ptr - RSTK_STEP;
                    if (st_q.ir == OP_RET_IRQ && act_hi[3]) begin
                      st_d.act  = st_q.act & ~(8'h01 << act_hi[2:0]);
                      st_d.pend = (st_q.pend & ~(8'h01 << act_hi[2:0])) |
                                  (io_op ? 8'h00 : irq_req);
                    end
                  end
                end
                default: ;
              endcase
            end
            GRP_PLOAD: begin
              unique case (st_q.ir[1:0])
                2'h0: st_d.estk_ptr    = {second_item, st_q.top_item};
                2'h1: st_d.rstk_ptr    = {second_item, st_q.top_item};
                2'h2: st_d.ram_ptr_one = {second_item, st_q.top_item};
                2'h3: st_d.ram_ptr_two = {second_item, st_q.top_item};
              endcase
              if (st_q.ir[1:0] != 2'h0) begin
                st_d.top_item = st_q.ram[8'(st_q.estk_ptr - ONE8)];
                st_d.estk_ptr = st_q.estk_ptr - TWO8;
              end else begin
                st_d.top_item = st_q.ram[8'({second_item, st_q.top_item} - ONE8)];
                st_d.estk_ptr = 8'({second_item, st_q.top_item} - TWO8);
              end
            end
            GRP_BR, GRP_JMP, GRP_CALL: begin
              if (st_q.mcyc == CYC_ONE) begin
                st_d.fetch_ptr = st_q.fetch_ptr + ONE12;
                if (st_q.ir[7:4] == GRP_CALL) begin
                  st_d.rstk_ptr              = rs_up;
                  st_d.ram[rs_up]            = st_d.fetch_ptr[3:0];
                  st_d.ram[8'(rs_up - ONE8)] = st_d.fetch_ptr[7:4];
                  st_d.ram[8'(rs_up - TWO8)] = st_d.fetch_ptr[11:8];
                end
                if (st_q.ir[7:4] != GRP_BR || st_q.condition_flags[FLG_B]) begin
                  st_d.fetch_ptr = {st_q.ir[3:0], rom_data};
                end
              end
            end
            GRP_MEM: begin
              // Pre-increment moves before the access, post-decrement after it
              if (st_q.ir[3:2] == MODE_PREINC) begin
                mem_ptr = mem_ptr + ONE8;
                mem_new = mem_ptr;
              end else if (st_q.ir[3:2] == MODE_POSTDEC) begin
                mem_new = mem_ptr - ONE8;
              end
              if (st_q.ir[MEM_STORE]) begin
                st_d.ram[mem_ptr] = st_q.top_item;
                st_d.top_item     = second_item;
                st_d.estk_ptr     = st_q.estk_ptr - ONE8;
              end else begin
                st_d.estk_ptr           = st_q.estk_ptr + ONE8;
                st_d.ram[st_d.estk_ptr] = st_q.top_item;
                st_d.top_item           = st_q.ram[mem_ptr];
              end
              if (st_q.ir[MEM_PTR2]) begin
                st_d.ram_ptr_two = mem_new;
              end else begin
                st_d.ram_ptr_one = mem_new;
              end
            end
            default: begin
              // Short vector call into the two lowest pages, to one of 64 entries eight locations apart
              if (st_q.mcyc == CYC_ONE) begin
                st_d.rstk_ptr              = rs_up;
                st_d.ram[rs_up]            = st_q.fetch_ptr[3:0];
                st_d.ram[8'(rs_up - ONE8)] = st_q.fetch_ptr[7:4];
                st_d.ram[8'(rs_up - TWO8)] = st_q.fetch_ptr[11:8];
                st_d.fetch_ptr             = {3'h0, st_q.ir[5:0], 3'h0};
              end
            end
          endcase
          // Last cycle: take the prefetched byte or enter acknowledge
          if (last_cyc) begin
            st_d.mcyc = CYC_ONE;
            if (take_irq) begin
              st_d.st = ST_IACK;
            end else begin
              st_d.ir        = rom_data;
              st_d.fetch_ptr = st_q.fetch_ptr + ONE12;
            end
          end
        end
      endcase
      // Table lookup borrows the ROM address for one cycle
      if (st_q.st == ST_RUN && st_q.ir == OP_TABLE && st_q.mcyc == CYC_ONE) begin
        st_d.rom_addr = rom_map({st_q.fetch_ptr[11:8], second_item, st_q.top_item},
                                st_q.rom_bank_select);
      end else begin
        st_d.rom_addr = rom_map(st_d.fetch_ptr, st_d.rom_bank_select);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge mclk) begin
    if (rst) begin
      st_q           <= '0;
      st_q.fetch_ptr <= RESET_VEC;
      st_q.rom_addr  <= {1'b0, RESET_VEC};
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs straight from the state flops
  assign rom_addr    = st_q.rom_addr;
  assign io_addr     = st_q.io_addr;
  assign io_wdata    = st_q.io_wdata;
  assign io_rd       = st_q.io_rd;
  assign io_wr       = st_q.io_wr;
  assign irq_active  = st_q.act;
  assign int_enable  = st_q.condition_flags[FLG_I];
  assign system_tick = st_q.system_tick;

  ////////////////////////////////////////////////////////////////////////
  // Checks

  bank_map_a: assert property (@(posedge mclk) disable iff (rst)
    rom_addr[12] |-> rom_addr[COMMON_BIT])
    else $error("bank bit set in common area");
  bank_zero_a: assert property (@(posedge mclk) disable iff (rst)
    (st_q.rom_bank_select & ~BANK_MASK) == 4'h0)
    else $error("unused bank bits nonzero");
  bank_port_a: assert property (@(posedge mclk) disable iff (rst)
    (io_wr || io_rd) |-> io_addr != BANK_PORT)
    else $error("bank port went out on bus");
  rstk_step_a: assert property (@(posedge mclk) disable iff (rst)
    $changed(st_q.rstk_ptr) && $past(st_q.ir[7:4]) != GRP_PLOAD |->
      (st_q.rstk_ptr == 8'($past(st_q.rstk_ptr) + RSTK_STEP)) ||
      (st_q.rstk_ptr == 8'($past(st_q.rstk_ptr) - RSTK_STEP)))
    else $error("return pointer step not four");
  tick_toggle_a: assert property (@(posedge mclk) disable iff (rst)
    $changed(st_q.fetch_ptr) |-> !st_q.system_tick ##1 st_q.system_tick ##1 !st_q.system_tick)
    else $error("fetch pointer off machine cycle");
  ie_reset_a: assert property (@(posedge mclk)
    $past(rst) |-> !int_enable)
    else $error("enable flag not cleared by reset");
  ie_rise_a: assert property (@(posedge mclk) disable iff (rst)
    $rose(int_enable) |-> $past(st_q.ir) == OP_UNMASK || $past(st_q.ir) == OP_SLEEP)
    else $error("enable flag set by other op");
  irq_gate_a: assert property (@(posedge mclk) disable iff (rst)
    $rose(st_q.st == ST_IACK) |-> $past(int_enable) && $past(st_q.pend != 8'h00))
    else $error("irq entered while disabled");
  // A write that follows at once may keep the strobe up, so only a lone write must end
  io_pulse_a: assert property (@(posedge mclk) disable iff (rst)
    io_wr && $past(io_wr) && st_q.ir != OP_OUT |=> !io_wr)
    else $error("io write strobe too long");
  carry_bool_a: assert property (@(posedge mclk) disable iff (rst)
    st_q.system_tick && st_q.st == ST_RUN && st_q.ir[7:4] == GRP_ALU &&
    st_q.ir[3:0] >= ALU_AND && st_q.ir[3:0] <= ALU_XOR |=> $stable(st_q.condition_flags[FLG_C]))
    else $error("boolean op changed carry");

endmodule
`default_nettype wire

// *** verif/scd_periph_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module scd_periph_model (
  input  wire logic        mclk,
  input  wire logic [12:0] rom_addr,
  input  wire logic [3:0]  io_addr,
  input  wire logic [3:0]  io_wdata,
  input  wire logic        io_rd,
  input  wire logic        io_wr,
  output var  logic [7:0]  rom_data,
  output var  logic [3:0]  io_rdata
);
  logic [7:0] rom [0:8191];
  logic [3:0] regs [0:15];
  // Program store answers at once from the address
  assign rom_data = rom[rom_addr];
  // Outside the strobe the bus shows junk, so late sampling is caught
  assign io_rdata = io_rd ? regs[io_addr] : ~regs[io_addr];
  // Writes are idempotent, so taking both strobe edges is harmless
  always @(posedge mclk) begin
    if (io_wr) begin
      regs[io_addr] <= io_wdata;
    end
  end
endmodule
`default_nettype wire

// *** verif/stack_cpu_core_datapath_tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module stack_cpu_core_datapath_tb_top;
  import scd_pkg::*;
  logic mclk, rst, io_rd, io_wr, int_enable, system_tick, io_wr_q;
  logic [7:0] irq_req, rom_data, irq_active;
  logic [3:0] io_rdata, io_addr, io_wdata, rnd;
  logic [12:0] rom_addr;
  logic [7:0] exp_q [$];
  int fails, tests_run;
  scd_core dut (.mclk, .rst, .rom_data, .io_rdata, .irq_req, .rom_addr, .io_addr,
    .io_wdata, .io_rd, .io_wr, .irq_active, .int_enable, .system_tick);
  scd_periph_model p (.mclk, .rom_addr, .io_addr, .io_wdata, .io_rd, .io_wr,
    .rom_data, .io_rdata);
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  task automatic check(string what, logic [12:0] seen, logic [12:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    if (fails == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic load(int a, logic [7:0] b []);
    foreach (b[i]) p.rom[a + i] = b[i];
  endtask
  // Bounded wait until only n writes are still outstanding
  task automatic wait_left(int n);
    for (int i = 0; exp_q.size() > n; i++) begin
      if (i > 3000) begin
        fails++;
        tally_and_finish();
      end
      @(negedge mclk);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Every new write strobe is matched against the model's next entry
  always @(posedge mclk) begin
    io_wr_q <= io_wr;
    if (io_wr && !io_wr_q) begin
      check("io write", {5'h00, io_addr, io_wdata}, {5'h00, exp_q.size() ? exp_q[0] : 8'hff});
      if (exp_q.size() > 0) exp_q.delete(0);
      if (io_addr == 4'h8) check("irq active", 13'(irq_active), 13'h002);
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    irq_req = 8'h00;
    fails = 0;
    tests_run = 0;
    rnd = 4'($urandom(32'h7944ea67));
    rnd = 4'($urandom);
    for (int i = 0; i < 8192; i++) p.rom[i] = OP_NOP;
    for (int i = 0; i < 16; i++) p.regs[i] = 4'h0;
    p.regs[5] = rnd;
    // Out, add, in, bank switch, jump into upper half of the bank
    load(12'h008, '{8'h1a, 8'h13, 8'h23, 8'h15, 8'h17, 8'h01, 8'h14, 8'h23, 8'h15,
      8'h22, 8'h16, 8'h23, 8'h14, 8'h1d, 8'h23, 8'h58, 8'h00});
    load(13'h0800, '{8'h10, 8'h12, 8'h23});
    // Bank 1: return pointer load, sub and and, flags read, table, branches, call, loop
    load(13'h1800, '{8'h11, 8'h12, 8'h23, 8'h1d, 8'h22, 8'h17, 8'h23, 8'h1f, 8'h10, 8'h31,
      8'h13, 8'h15, 8'h02, 8'h16, 8'h03, 8'h2a, 8'h19, 8'h23, 8'h1a, 8'h23, 8'h1f, 8'h10,
      8'h2b, 8'h23, 8'h48, 8'h00, 8'h28, 8'h48, 8'h1f, 8'h1b, 8'h23, 8'h68, 8'hc0, 8'h25,
      8'h58, 8'h22});
    // Subroutine: pointer load, pre-increment store, post-decrement fetch, return
    load(13'h18c0, '{8'h13, 8'h12, 8'h32, 8'h1b, 8'h75, 8'h78, 8'h1e, 8'h23, 8'h2c});
    // Table constant only in bank 1, the bank 0 copy reads as zero
    load(13'h18f0, '{8'h5c});
    load(12'h080, '{8'h19, 8'h18, 8'h23, 8'h2d});
    // 3-5 borrows so flags read carry only; and keeps the borrow; table gives 5 and c
    exp_q = '{8'h3a, {4'h4, 4'(5 + 7)}, {4'h6, rnd}, 8'h21, {4'h7, BANK_MASK},
      {4'h9, 4'(1 << FLG_C)}, {4'ha, 4'(4'(3 - 5) & 4'h6)}, 8'hc5, 8'heb, 8'h89};
    repeat (6) @(negedge mclk);
    check("reset enable", 13'(int_enable), 13'h0000);
    check("reset fetch", rom_addr, 13'(RESET_VEC));
    rst = 1'b0;
    wait_left(1);
    repeat (10) @(negedge mclk);
    check("enable set", 13'(int_enable), 13'h0001);
    irq_req = 8'h02;
    repeat (6) @(negedge mclk);
    irq_req = 8'h00;
    wait_left(0);
    repeat (40) @(negedge mclk);
    check("irq done", 13'(irq_active), 13'h0000);
    check("bank bit", 13'(rom_addr[12]), 13'h0001);
    tally_and_finish();
  end
endmodule
`default_nettype wire
